// ===== include/tmr_defines.vh
// register map, field positions, reset values and counts for the 16-bit timer
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH
`define TMR_ADDR_CTRL_TWO    4'h1
`define TMR_ADDR_CTRL_ONE    4'h2
`define TMR_ADDR_STATUS      4'h3
`define TMR_ADDR_CAP1_HI     4'h4
`define TMR_ADDR_CAP1_LO     4'h5
`define TMR_ADDR_CNT_HI      4'h8
`define TMR_ADDR_CNT_LO      4'h9
`define TMR_ADDR_SHD_HI      4'ha
`define TMR_ADDR_SHD_LO      4'hb
`define TMR_ADDR_CAP2_HI     4'hc
`define TMR_ADDR_CAP2_LO     4'hd
`define TMR_CNT_RESET        16'hfffc
`define TMR_CNT_MAX          16'hffff
`define TMR_CR1_OVF_IE       7
`define TMR_CR1_CAP_IE       6
`define TMR_CR1_CAP1_EDGE    1
`define TMR_CR2_OPM          5
`define TMR_CR2_PWM          4
`define TMR_CR2_CC_HI        3
`define TMR_CR2_CC_LO        2
`define TMR_CR2_CAP2_EDGE    1
`define TMR_CR2_EXT_EDGE     0
`define TMR_SR_CAP1          7
`define TMR_SR_OVF           5
`define TMR_SR_CAP2          4
`define TMR_CC_DIV2          2'b00
`define TMR_CC_DIV4          2'b01
`define TMR_CC_DIV8          2'b10
`define TMR_CC_EXT           2'b11
`endif

// ===== rtl/tmr_edge_detect.v
// synchroniser and selectable edge detector for one input pin
`timescale 1ns/10ps
module tmr_edge_detect (
    // clock and reset
    input  wire clock,
    input  wire resetn,
    // pin and edge choice, 1 selects rising
    input  wire pin,
    input  wire rising_sel,
    // one-cycle pulse on the selected edge
    output reg  edge_pulse
);
    reg  sync1_reg;
    reg  sync2_reg;
    reg  last_reg;
    wire seen;

    // samples on the falling edge of the cpu clock
    always @(negedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= 1'b0;
        end else begin
            sync1_reg <= pin;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync2_reg <= 1'b0;
            last_reg  <= 1'b0;
        end else begin
            sync2_reg <= sync1_reg;
            last_reg  <= sync2_reg;
        end
    end

    assign seen = rising_sel ? (sync2_reg & ~last_reg) : (~sync2_reg & last_reg);

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            edge_pulse <= 1'b0;
        end else begin
            edge_pulse <= seen;
        end
    end
endmodule

// ===== rtl/tmr_prescaler.v
// prescaler that yields one count tick per selected timer clock period
`timescale 1ns/10ps
`include "tmr_defines.vh"
module tmr_prescaler (
    // clock and reset
    input  wire       clock,
    input  wire       resetn,
    // selection, freeze and restart
    input  wire [1:0] clock_select_field,
    input  wire       freeze,
    input  wire       restart,
    input  wire       ext_tick,
    // count enable pulse
    output reg        tick
);
    reg  [2:0] div_reg;
    wire [2:0] div_next;
    reg        hit;

    assign div_next = restart ? 3'h0 : (freeze ? div_reg : div_reg + 3'h1);

    always @* begin
        case (clock_select_field)
            `TMR_CC_DIV2: hit = (div_reg[0] == 1'b1);
            `TMR_CC_DIV4: hit = (div_reg[1:0] == 2'h3);
            `TMR_CC_DIV8: hit = (div_reg == 3'h7);
            default:      hit = ext_tick;
        endcase
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            div_reg <= 3'h0;
            tick    <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick    <= hit & ~freeze & ~restart;
        end
    end
endmodule

// ===== rtl/tmr_timer16.v
// 16-bit free-running timer with prescaler, external clock and two input captures
//
// How it works
// RULE_01: count rate from cpu/2, /4, /8 or external
// RULE_02: 16-bit up-counter read as high and low bytes
// RULE_03: writing either low byte reloads fffc
// RULE_04: reset value and only reload is fffc
// RULE_05: shadow low byte never clears overflow flag
// RULE_06: high read freezes low byte until low read
// RULE_07: lone low read returns live low byte
// RULE_08: overflow flag set on ffff to 0000 wrap
// RULE_09: overflow request needs flag, enable, clear mask
// RULE_10: overflow clears via status read then low access
// RULE_11: runs in wait, freezes in halt
// RULE_12: clock field 11 picks external clock
// RULE_13: edge bit picks external clock polarity
// RULE_14: external edges synchronised on cpu falling edge
// RULE_15: external clock under a quarter cpu rate
// RULE_16: capture latches count on active edge
// RULE_17: each capture channel has own edge bit
// RULE_18: capture sets flag, shared enable requests interrupt
// RULE_19: capture flag clears via status then low access
// RULE_20: capture high read blocks captures until low read
// RULE_21: pulse or pwm mode leaves only channel two
// RULE_22: capture pins always feed the timer
// RULE_23: all conditions merge into one request
`timescale 1ns/10ps
`include "tmr_defines.vh"
module tmr_timer16 (
    // clock and reset
    input  wire       clock,
    input  wire       resetn,
    // register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_write,
    input  wire       reg_read,
    output reg  [7:0] reg_rdata,
    // pins
    input  wire       ext_clock_input,
    input  wire       capture_input_one,
    input  wire       capture_input_two,
    // power modes and cpu mask
    input  wire       halt_mode,
    input  wire       cpu_irq_mask,
    // interrupt request
    output reg        timer_irq
);
    reg  [15:0] count_reg;
    reg  [15:0] count_next;
    reg  [7:0]  low_buf_reg;
    reg         low_buf_valid_reg;
    reg  [7:0]  control_register_one;
    reg  [7:0]  control_register_two;
    reg  [15:0] capture_one_value;
    reg  [15:0] capture_two_value;
    reg         overflow_flag;
    reg         cap1_flag_reg;
    reg         cap2_flag_reg;
    reg         ovf_armed_reg;
    reg         cap1_armed_reg;
    reg         cap2_armed_reg;
    reg         cap1_block_reg;
    reg         cap2_block_reg;
    reg  [7:0]  rdata_next;
    wire        tick;
    wire        ext_edge;
    wire        cap1_edge;
    wire        cap2_edge;
    wire        wr_cnt_lo;
    wire        wr_shd_lo;
    wire        rd_status;
    wire        acc_cnt_lo;
    wire        acc_cap1_lo;
    wire        acc_cap2_lo;
    wire        rd_cnt_hi;
    wire        rd_cnt_lo;
    wire        rd_cap1_hi;
    wire        rd_cap2_hi;
    wire        wrap;
    wire        one_pulse_mode;
    wire        pwm_mode;
    wire        cap1_take;
    wire        cap2_take;
    wire        irq_next;

    function hit;
        input       strobe;
        input [3:0] addr;
        input [3:0] want;
        begin
            hit = strobe & (addr == want);
        end
    endfunction

    assign wr_cnt_lo   = hit(reg_write, reg_addr, `TMR_ADDR_CNT_LO);
    assign wr_shd_lo   = hit(reg_write, reg_addr, `TMR_ADDR_SHD_LO);
    assign rd_status   = hit(reg_read, reg_addr, `TMR_ADDR_STATUS);
    assign rd_cnt_hi   = hit(reg_read, reg_addr, `TMR_ADDR_CNT_HI) | hit(reg_read, reg_addr, `TMR_ADDR_SHD_HI);
    assign rd_cnt_lo   = hit(reg_read, reg_addr, `TMR_ADDR_CNT_LO) | hit(reg_read, reg_addr, `TMR_ADDR_SHD_LO);
    assign acc_cnt_lo  = hit(reg_read | reg_write, reg_addr, `TMR_ADDR_CNT_LO); // RULE_05
    assign acc_cap1_lo = hit(reg_read | reg_write, reg_addr, `TMR_ADDR_CAP1_LO);
    assign acc_cap2_lo = hit(reg_read | reg_write, reg_addr, `TMR_ADDR_CAP2_LO);
    assign rd_cap1_hi  = hit(reg_read, reg_addr, `TMR_ADDR_CAP1_HI);
    assign rd_cap2_hi  = hit(reg_read, reg_addr, `TMR_ADDR_CAP2_HI);

    assign one_pulse_mode = control_register_two[`TMR_CR2_OPM];
    assign pwm_mode       = control_register_two[`TMR_CR2_PWM];

    // external clock edge, sampled on the falling cpu edge
    tmr_edge_detect u_ext_edge (
        .clock      (clock),
        .resetn     (resetn),
        .pin        (ext_clock_input),
        .rising_sel (control_register_two[`TMR_CR2_EXT_EDGE]),
        .edge_pulse (ext_edge)
    ); // RULE_13 RULE_14

    // capture pins are never gated by pin direction
    tmr_edge_detect u_cap1_edge (
        .clock      (clock),
        .resetn     (resetn),
        .pin        (capture_input_one),
        .rising_sel (control_register_one[`TMR_CR1_CAP1_EDGE]),
        .edge_pulse (cap1_edge)
    ); // RULE_17 RULE_22

    tmr_edge_detect u_cap2_edge (
        .clock      (clock),
        .resetn     (resetn),
        .pin        (capture_input_two),
        .rising_sel (control_register_two[`TMR_CR2_CAP2_EDGE]),
        .edge_pulse (cap2_edge)
    ); // RULE_17 RULE_22

    // faster external clocks lose edges in the synchroniser
    tmr_prescaler u_presc (
        .clock              (clock),
        .resetn             (resetn),
        .clock_select_field (control_register_two[`TMR_CR2_CC_HI:`TMR_CR2_CC_LO]),
        .freeze             (halt_mode),
        .restart            (wr_cnt_lo | wr_shd_lo),
        .ext_tick           (ext_edge),
        .tick               (tick)
    ); // RULE_01 RULE_11 RULE_12 RULE_15

    assign wrap = tick & (count_reg == `TMR_CNT_MAX); // RULE_08

    always @* begin
        count_next = count_reg;
        if (wr_cnt_lo | wr_shd_lo) begin
            count_next = `TMR_CNT_RESET; // RULE_03
        end else if (tick) begin
            count_next = count_reg + 16'h0001; // RULE_02
        end
    end

    // channel one captures nothing in one-pulse and pwm modes
    assign cap1_take = cap1_edge & ~cap1_block_reg & ~one_pulse_mode & ~pwm_mode; // RULE_21 RULE_20
    assign cap2_take = cap2_edge & ~cap2_block_reg; // RULE_20

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= `TMR_CNT_RESET; // RULE_04
        end else begin
            count_reg <= count_next;
        end
    end

    // byte read buffer
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            low_buf_reg       <= 8'h00;
            low_buf_valid_reg <= 1'b0;
        end else if (rd_cnt_hi) begin
            if (!low_buf_valid_reg) begin
                low_buf_reg <= count_reg[7:0]; // RULE_06
            end
            low_buf_valid_reg <= 1'b1;
        end else if (rd_cnt_lo) begin
            low_buf_valid_reg <= 1'b0; // RULE_07
        end
    end

    // control registers
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            control_register_one <= 8'h00;
            control_register_two <= 8'h00;
        end else begin
            if (hit(reg_write, reg_addr, `TMR_ADDR_CTRL_ONE)) begin
                control_register_one <= reg_wdata;
            end
            if (hit(reg_write, reg_addr, `TMR_ADDR_CTRL_TWO)) begin
                control_register_two <= reg_wdata;
            end
        end
    end

    // captures and their read interlocks
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            capture_one_value <= 16'h0000;
            capture_two_value <= 16'h0000;
            cap1_block_reg    <= 1'b0;
            cap2_block_reg    <= 1'b0;
        end else begin
            if (cap1_take) begin
                capture_one_value <= count_reg; // RULE_16
            end
            if (cap2_take) begin
                capture_two_value <= count_reg; // RULE_16
            end
            if (rd_cap1_hi) begin
                cap1_block_reg <= 1'b1; // RULE_20
            end else if (hit(reg_read, reg_addr, `TMR_ADDR_CAP1_LO)) begin
                cap1_block_reg <= 1'b0;
            end
            if (rd_cap2_hi) begin
                cap2_block_reg <= 1'b1; // RULE_20
            end else if (hit(reg_read, reg_addr, `TMR_ADDR_CAP2_LO)) begin
                cap2_block_reg <= 1'b0;
            end
        end
    end

    // two-step flag clear; a new event in the clearing cycle wins
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            overflow_flag  <= 1'b0;
            cap1_flag_reg  <= 1'b0;
            cap2_flag_reg  <= 1'b0;
            ovf_armed_reg  <= 1'b0;
            cap1_armed_reg <= 1'b0;
            cap2_armed_reg <= 1'b0;
        end else begin
            if (wrap) begin
                overflow_flag <= 1'b1; // RULE_08
            end else if (ovf_armed_reg & acc_cnt_lo) begin
                overflow_flag <= 1'b0; // RULE_10
            end
            if (cap1_take) begin
                cap1_flag_reg <= 1'b1; // RULE_18
            end else if (cap1_armed_reg & acc_cap1_lo) begin
                cap1_flag_reg <= 1'b0; // RULE_19
            end
            if (cap2_take) begin
                cap2_flag_reg <= 1'b1; // RULE_18
            end else if (cap2_armed_reg & acc_cap2_lo) begin
                cap2_flag_reg <= 1'b0; // RULE_19
            end
            if (rd_status) begin
                ovf_armed_reg  <= overflow_flag; // RULE_10
                cap1_armed_reg <= cap1_flag_reg; // RULE_19
                cap2_armed_reg <= cap2_flag_reg; // RULE_19
            end else begin
                if (acc_cnt_lo) begin
                    ovf_armed_reg <= 1'b0;
                end
                if (acc_cap1_lo) begin
                    cap1_armed_reg <= 1'b0;
                end
                if (acc_cap2_lo) begin
                    cap2_armed_reg <= 1'b0;
                end
            end
        end
    end

    // read mux
    always @* begin
        rdata_next = 8'h00;
        case (reg_addr)
            `TMR_ADDR_CTRL_ONE: rdata_next = control_register_one;
            `TMR_ADDR_CTRL_TWO: rdata_next = control_register_two;
            `TMR_ADDR_STATUS:   rdata_next = {cap1_flag_reg, 1'b0, overflow_flag, cap2_flag_reg, 4'h0};
            `TMR_ADDR_CAP1_HI:  rdata_next = capture_one_value[15:8];
            `TMR_ADDR_CAP1_LO:  rdata_next = capture_one_value[7:0];
            `TMR_ADDR_CAP2_HI:  rdata_next = capture_two_value[15:8];
            `TMR_ADDR_CAP2_LO:  rdata_next = capture_two_value[7:0];
            `TMR_ADDR_CNT_HI:   rdata_next = count_reg[15:8];
            `TMR_ADDR_SHD_HI:   rdata_next = count_reg[15:8];
            `TMR_ADDR_CNT_LO:   rdata_next = low_buf_valid_reg ? low_buf_reg : count_reg[7:0]; // RULE_06 RULE_07
            `TMR_ADDR_SHD_LO:   rdata_next = low_buf_valid_reg ? low_buf_reg : count_reg[7:0]; // RULE_05
            default:            rdata_next = 8'h00;
        endcase
    end

    // request waits while the cpu mask is set, since the flags persist
    assign irq_next = ~cpu_irq_mask &
                      ((overflow_flag & control_register_one[`TMR_CR1_OVF_IE]) |
                       ((cap1_flag_reg | cap2_flag_reg) & control_register_one[`TMR_CR1_CAP_IE])); // RULE_09 RULE_18 RULE_23

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
            timer_irq <= 1'b0;
        end else begin
            reg_rdata <= reg_read ? rdata_next : 8'h00;
            timer_irq <= irq_next;
        end
    end
endmodule

// ===== tb/tmr_pin_model.sv
// pin-side model: external count clock and the two capture inputs
`timescale 1ns/10ps
module tmr_pin_model (
    // clock
    input wire clock,
    // pins
    output reg ext_clock_input,
    output reg capture_input_one,
    output reg capture_input_two
);
    initial begin
        ext_clock_input = 1'b0;
        capture_input_one = 1'b0;
        capture_input_two = 1'b0;
    end
    // high lasts g >= 5 cycles and low g + 1, so at least eleven cpu falling edges separate active edges
    task ext_pulses(input int n, input int g);
        repeat (n) begin
            @(posedge clock) ext_clock_input <= 1'b1;
            repeat (g) @(posedge clock);
            ext_clock_input <= 1'b0;
            repeat (g) @(posedge clock);
        end
    endtask
    // level held long enough to pass the synchroniser before anything else moves
    task cap_level(input int ch, input logic lvl);
        @(posedge clock);
        if (ch == 1) capture_input_one <= lvl;
        else capture_input_two <= lvl;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ===== tb/tmr_timer16_assertions.sv
// concurrent checks on the timer register port and request output
`timescale 1ns/10ps
module tmr_timer16_assertions (
    // clock and reset
    input wire       clock,
    input wire       resetn,
    // register port
    input wire [3:0] reg_addr,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    // power mode, mask and request
    input wire       halt_mode,
    input wire       cpu_irq_mask,
    input wire       timer_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // halt is required around every frozen-count check so no tick can land between reads
    wire rd_hi   = reg_read && reg_addr == 4'h8 && halt_mode && !reg_write;
    wire rd_stat = reg_read && reg_addr == 4'h3 && halt_mode;

    rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_zero_a: assert property (reg_read && reg_addr inside {4'h0, 4'h6, 4'h7, 4'he, 4'hf}
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    irq_masked_a: assert property (cpu_irq_mask |=> !timer_irq)
        else $error("request raised while masked");
    reload_high_a: assert property ((reg_write && reg_addr inside {4'h9, 4'hb} && halt_mode) ##1 rd_hi
        |=> reg_rdata == 8'hff) else $error("low byte write did not reload");
    halt_freeze_a: assert property (halt_mode [*3] ##1 rd_hi ##1 rd_hi |=> $stable(reg_rdata))
        else $error("count moved during halt");
    shadow_match_a: assert property (halt_mode [*3] ##1 (reg_read && reg_addr == 4'ha && halt_mode) ##1 rd_hi
        |=> $stable(reg_rdata)) else $error("shadow and main high differ");
    ovf_clear_a: assert property (rd_stat ##1 (reg_rdata[5] && reg_read && reg_addr == 4'h9 && halt_mode)
        ##1 rd_stat |=> !reg_rdata[5]) else $error("overflow flag not cleared");
    shadow_keep_a: assert property (rd_stat ##1 (reg_rdata[5] && reg_read && reg_addr == 4'hb && halt_mode)
        ##1 rd_stat |=> reg_rdata[5]) else $error("shadow access cleared overflow");
endmodule

bind tmr_timer16 tmr_timer16_assertions chk_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .halt_mode(halt_mode),
    .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));

// ===== tb/tmr_timer16_tb.sv
// self-checking bench for the 16-bit timer with input capture
`timescale 1ns/10ps
`include "tmr_defines.vh"
module tmr_timer16_tb;
    reg        clock;
    reg        resetn;
    reg  [3:0] reg_addr;
    reg  [7:0] reg_wdata;
    reg        reg_write;
    reg        reg_read;
    wire [7:0] reg_rdata;
    wire       ext_clock_input;
    wire       capture_input_one;
    wire       capture_input_two;
    reg        halt_mode;
    reg        cpu_irq_mask;
    wire       timer_irq;
    integer    error_cnt;
    integer    checked;
    reg  [7:0] rq;
    reg [15:0] v;
    reg [15:0] q_cap[$];
    int        n;
    int        i;
    int        d;

    tmr_timer16 uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_clock_input(ext_clock_input),
        .capture_input_one(capture_input_one), .capture_input_two(capture_input_two),
        .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq));
    tmr_pin_model pm (.clock(clock), .ext_clock_input(ext_clock_input),
        .capture_input_one(capture_input_one), .capture_input_two(capture_input_two));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task chk(input string name, input [15:0] got, input [15:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // strobe stays up until the next access or idle, so reads can follow back to back
    task acc(input w, input [3:0] a, input [7:0] dat);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge clock);
        #1 rq = reg_rdata;
    endtask
    task idle(input int c);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (c) @(posedge clock);
        #1;
    endtask
    task rd(input [3:0] a, input string name, input [7:0] exp);
        acc(1'b0, a, 8'h00);
        idle(1);
        chk(name, rq, exp);
    endtask
    task run(input int c);
        halt_mode <= 1'b0;
        idle(c);
        halt_mode <= 1'b1;
        idle(3);
    endtask
    task live_delta(input int lo, input int hi);
        acc(1'b0, 4'hb, 8'h00);
        idle(1);
        d = (rq + 256 - 'hfc) % 256;
        chk("count delta", d >= lo && d <= hi, 1);
    endtask
    task read_count;
        acc(1'b0, 4'h8, 8'h00);
        v[15:8] = rq;
        acc(1'b0, 4'h9, 8'h00);
        v[7:0] = rq;
        idle(1);
        q_cap.push_back(v);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        error_cnt = error_cnt + 1;
        final_report;
    end

    initial begin
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        halt_mode = 1'b1;
        cpu_irq_mask = 1'b0;
        error_cnt = 0;
        checked = 0;
        void'($urandom(32'h623fe287));
        repeat (10) @(posedge clock);
        #1 resetn = 1'b1;
        // reset value, halt freeze, shadow, unmapped place
        acc(1'b0, 4'h8, 8'h00);
        chk("count hi", rq, 8'hff);
        acc(1'b0, 4'h8, 8'h00);
        chk("count hi again", rq, 8'hff);
        acc(1'b0, 4'ha, 8'h00);
        chk("shadow hi", rq, 8'hff);
        acc(1'b0, 4'h8, 8'h00);
        acc(1'b0, 4'h9, 8'h00);
        chk("count lo", rq, 8'hfc);
        acc(1'b1, 4'hf, 8'h55);
        rd(4'hf, "unmapped", 8'h00);
        rd(4'h3, "status", 8'h00);
        $display("test reset done");
        // buffered read across a wrap, overflow flag and request
        acc(1'b1, 4'h9, 8'h00);
        acc(1'b0, 4'h8, 8'h00);
        idle(1);
        chk("reload hi", rq, 8'hff);
        n = 16 + 2 * ($urandom % 16);
        run(n);
        rd(4'h8, "hi after wrap", 8'h00);
        rd(4'h9, "buffered lo", 8'hfc);
        live_delta(n / 2 - 2, n / 2 + 1);
        acc(1'b1, 4'h2, 8'h80);
        idle(2);
        chk("ovf request", timer_irq, 1);
        cpu_irq_mask <= 1'b1;
        idle(2);
        chk("masked request", timer_irq, 0);
        cpu_irq_mask <= 1'b0;
        acc(1'b0, 4'h3, 8'h00);
        chk("ovf flag", rq[5], 1);
        acc(1'b0, 4'hb, 8'h00);
        acc(1'b0, 4'h3, 8'h00);
        chk("ovf kept", rq[5], 1);
        acc(1'b0, 4'h9, 8'h00);
        rd(4'h3, "ovf cleared", 8'h00);
        idle(1);
        chk("request gone", timer_irq, 0);
        $display("test overflow done");
        // prescaler rates, then external clock on both edges
        for (i = 0; i < 3; i = i + 1) begin
            acc(1'b1, 4'h1, {4'h0, i[1:0], 2'b00});
            acc(1'b1, 4'h9, 8'h00);
            idle(1);
            run(64);
            live_delta((64 >> (i + 1)) - 2, (64 >> (i + 1)) + 2);
        end
        for (i = 0; i < 2; i = i + 1) begin
            acc(1'b1, 4'h1, {7'h06, i[0]});
            acc(1'b1, 4'hb, 8'h00);
            halt_mode <= 1'b0;
            idle(2);
            pm.ext_pulses(10, 5 + 4 * i);
            run(10);
            rd(4'hb, "ext count", 8'h06);
        end
        $display("test clock select done");
        // captures, edge selects, flags, blocking, pulse mode
        acc(1'b1, 4'h1, 8'h00);
        acc(1'b1, 4'h2, 8'h42);
        acc(1'b0, 4'h3, 8'h00);
        acc(1'b0, 4'h9, 8'h00);
        run(4 + $urandom % 40);
        read_count;
        pm.cap_level(1, 1'b1);
        pm.cap_level(2, 1'b1);
        rd(4'h3, "cap1 only", 8'h80);
        chk("cap request", timer_irq, 1);
        pm.cap_level(2, 1'b0);
        rd(4'h3, "both caps", 8'h90);
        for (i = 0; i < 2; i = i + 1) begin
            rd(i ? 4'hc : 4'h4, "cap hi", q_cap[$][15:8]);
            rd(i ? 4'hd : 4'h5, "cap lo", q_cap[$][7:0]);
        end
        rd(4'h3, "caps cleared", 8'h00);
        acc(1'b0, 4'h4, 8'h00);
        run(4 + $urandom % 40);
        pm.cap_level(1, 1'b0);
        pm.cap_level(1, 1'b1);
        rd(4'h3, "blocked flag", 8'h00);
        rd(4'h5, "blocked lo", q_cap[$][7:0]);
        read_count;
        pm.cap_level(1, 1'b0);
        pm.cap_level(1, 1'b1);
        rd(4'h3, "unblocked", 8'h80);
        rd(4'h4, "new cap hi", q_cap[$][15:8]);
        rd(4'h5, "new cap lo", q_cap[$][7:0]);
        acc(1'b1, 4'h1, 8'h20);
        idle(1);
        pm.cap_level(1, 1'b0);
        pm.cap_level(1, 1'b1);
        pm.cap_level(2, 1'b1);
        pm.cap_level(2, 1'b0);
        rd(4'h3, "pulse mode caps", 8'h10);
        $display("test capture done");
        final_report;
    end
endmodule
